/* File: shared/lhci_pkg.sv */
/*
 Shared constants, state enumerations and instruction codes of the
 display controller's serial readback and parallel instruction path.
 Assumes a single 100 MHz ref_clk on both ends.
*/
package lhci_pkg;
	localparam int CLK_MHZ = 100;
	localparam int LONG_WAIT_MS = 2;
	localparam int LONG_WAIT_CYC = LONG_WAIT_MS * 1000 * CLK_MHZ;
	localparam int SHORT_WAIT_US = 40;
	// Strictly more than the printed figure
	localparam int SHORT_WAIT_CYC = SHORT_WAIT_US * CLK_MHZ + 1;
	localparam int EXEC_US = 40;
	localparam int EXEC_CYC = EXEC_US * CLK_MHZ;
	localparam int HOST_EXEC_CYC = EXEC_CYC + 2;
	localparam int POLL_SETTLE_CYC = 2;
	localparam int CNT_W = 18;
	localparam int BUSY_W = 13;
	localparam int QTR_CYC = 5;
	localparam int RAM_DEPTH = 80;
	localparam int AC_W = 7;
	localparam logic [6:0] SLAVE_ADDR = 7'h3A;
	localparam int CO_BIT = 7;
	localparam int RS_BIT = 6;
	localparam int RW_BIT = 5;
	localparam logic [7:0] CTRL_READ = 8'h60;
	localparam logic [7:0] FS_8BIT = 8'h30;
	localparam logic [2:0] FS_PREFIX = 3'h1;
	localparam int FS_WIDE_BIT = 4;
	localparam logic [7:0] DISP_OFF = 8'h08;
	localparam int DISP_ON_BIT = 2;
	localparam logic [7:0] CLEAR_CMD = 8'h01;
	localparam logic [5:0] ENTRY_PREFIX = 6'h01;
	localparam logic [7:0] BLANK_CHAR = 8'h20;
	localparam logic [2:0] FS_INIT_COUNT = 3'h3;
	localparam logic [2:0] LAST_INIT_IDX = 3'h6;
	localparam logic [2:0] USER_IDX = 3'h7;

	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_ACK, D_CTRL, D_TX, D_MACK, D_LOAD
	} lhci_dstate_t;
	typedef enum logic [1:0] {H_WAIT, H_ISSUE, H_READY, H_SER} lhci_hstate_t;
	typedef enum logic [1:0] {S_START, S_BYTE, S_STOP} lhci_sstate_t;
	typedef enum logic [2:0] {
		I_NONE, I_CLEAR, I_ENTRY, I_DISPLAY, I_FUNC
	} lhci_instr_t;
endpackage

/* File: shared/lhci_bus_if.sv */
/*
 Link between host and display controller: serial pair with open-drain data line and
 the 8-bit parallel instruction port. Both ends share ref_clk; the
 bench connects the clock and reset to each end.
*/
`timescale 1ns/100ps
`default_nettype none
interface lhci_bus_if;
	logic scl;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;
	logic sdaLine;
	logic registerSelect;
	logic readWrite;
	logic [7:0] dataBus;
	logic enable;
	logic busyFlag;

	// Pulled up unless a driver pulls low
	assign sdaLine = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

	modport device (
		input scl, sdaLine, registerSelect, readWrite, dataBus, enable,
		output sdaDevOut, sdaDevOe, busyFlag
	);
	modport host (
		input sdaLine, busyFlag,
		output scl, sdaHostOut, sdaHostOe, registerSelect, readWrite,
		dataBus, enable
	);
endinterface
`default_nettype wire

/* File: design/lhci_device_end.sv */
/*
 Display controller end: serial slave for display data readback and
 parallel instruction decoder with display data RAM and busy timer.
 Assumes the host end runs on the same ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module lhci_device_end (
	input wire logic ref_clk,
	input wire logic rst_n,
	lhci_bus_if.device bus,
	output logic [6:0] addressCounter,
	output logic [7:0] dataLatch,
	output logic displayOn,
	output logic wideBus,
	output logic [2:0] funcBits,
	output logic entryInc,
	output logic entryShift
);
	typedef struct packed {
		lhci_pkg::lhci_dstate_t st;
		logic sclPrev;
		logic sdaPrev;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic rdMode;
		logic sdaOe;
		logic [7:0] dataLatch;
		logic [6:0] ac;
		logic [lhci_pkg::RAM_DEPTH-1:0][7:0] ram;
		logic [lhci_pkg::BUSY_W-1:0] busyCnt;
		logic busy;
		logic [2:0] fsSeen;
		logic wide;
		logic [2:0] funcBits;
		logic dispOn;
		logic inc;
		logic shiftEn;
	} lhci_dev_t;

	lhci_dev_t r, next_r;
	logic sclRise, sclFall, startCond, stopCond;

	function automatic lhci_pkg::lhci_instr_t decodeInstr(
		input logic [7:0] b
	);
		casez (b)
			8'b0000_0001: decodeInstr = lhci_pkg::I_CLEAR;
			8'b0000_01??: decodeInstr = lhci_pkg::I_ENTRY;
			8'b0000_1???: decodeInstr = lhci_pkg::I_DISPLAY;
			8'b001?_????: decodeInstr = lhci_pkg::I_FUNC;
			default: decodeInstr = lhci_pkg::I_NONE;
		endcase
	endfunction

	function automatic logic [6:0] stepAc(input logic [6:0] a,
		input logic up);
		if (up) begin
			stepAc = (a == 7'(lhci_pkg::RAM_DEPTH - 1)) ? 7'h00 : a + 7'h01;
		end else begin
			stepAc = (a == 7'h00) ? 7'(lhci_pkg::RAM_DEPTH - 1) : a - 7'h01;
		end
	endfunction

	assign sclRise = bus.scl & ~r.sclPrev;
	assign sclFall = ~bus.scl & r.sclPrev;
	assign startCond = bus.scl & r.sclPrev & r.sdaPrev & ~bus.sdaLine;
	assign stopCond = bus.scl & r.sclPrev & ~r.sdaPrev & bus.sdaLine;

	always_comb begin
		next_r = r;
		next_r.sclPrev = bus.scl;
		next_r.sdaPrev = bus.sdaLine;
		if (r.busyCnt != '0) begin
			next_r.busyCnt = r.busyCnt - 1'b1;
		end
		// Parallel writes; reads of the port are not modelled
		if (bus.enable & ~bus.readWrite) begin
			next_r.busyCnt = lhci_pkg::BUSY_W'(lhci_pkg::EXEC_CYC);
			if (bus.registerSelect) begin
				next_r.ram[r.ac] = bus.dataBus;
				next_r.ac = stepAc(r.ac, r.inc);
			end else begin
				case (decodeInstr(bus.dataBus))
					lhci_pkg::I_CLEAR: begin
						for (int i = 0; i < lhci_pkg::RAM_DEPTH; i++) begin
							next_r.ram[i] = lhci_pkg::BLANK_CHAR;
						end
						next_r.ac = 7'h00;
						next_r.inc = 1'b1;
					end
					lhci_pkg::I_ENTRY: begin
						next_r.inc = bus.dataBus[1];
						next_r.shiftEn = bus.dataBus[0];
					end
					lhci_pkg::I_DISPLAY: begin
						next_r.dispOn = bus.dataBus[lhci_pkg::DISP_ON_BIT];
					end
					lhci_pkg::I_FUNC: begin
						next_r.wide = bus.dataBus[lhci_pkg::FS_WIDE_BIT];
						// Low nibble ignored during the reset sequence
						if (r.fsSeen < lhci_pkg::FS_INIT_COUNT) begin
							next_r.fsSeen = r.fsSeen + 3'h1;
						end else begin
							next_r.funcBits = bus.dataBus[3:1];
						end
					end
					default: begin
					end
				endcase
			end
		end
		next_r.busy = (next_r.busyCnt != '0);
		if (stopCond) begin
			next_r.st = lhci_pkg::D_IDLE;
			next_r.sdaOe = 1'b0;
		end else if (startCond) begin
			next_r.st = lhci_pkg::D_ADDR;
			next_r.bitCnt = 4'h0;
			next_r.sdaOe = 1'b0;
		end else begin
			case (r.st)
				lhci_pkg::D_ADDR, lhci_pkg::D_CTRL: begin
					if (sclRise && r.bitCnt < 4'h8) begin
						next_r.shift = {r.shift[6:0], bus.sdaLine};
						next_r.bitCnt = r.bitCnt + 4'h1;
					end else if (sclFall && r.bitCnt == 4'h8) begin
						next_r.sdaOe = 1'b1;
						next_r.st = lhci_pkg::D_ACK;
						if (r.st == lhci_pkg::D_ADDR) begin
							next_r.rdMode = r.shift[0];
							if (r.shift[7:1] != lhci_pkg::SLAVE_ADDR) begin
								next_r.sdaOe = 1'b0;
								next_r.st = lhci_pkg::D_IDLE;
							end
						end else if (r.shift[lhci_pkg::RS_BIT] &&
							r.shift[lhci_pkg::RW_BIT]) begin
							// Select RAM as read source and prefetch
							next_r.dataLatch = r.ram[r.ac];
							next_r.ac = stepAc(r.ac, r.inc);
						end
					end
				end
				lhci_pkg::D_ACK: begin
					if (sclFall) begin
						next_r.bitCnt = 4'h0;
						if (r.rdMode) begin
							next_r.shift = r.dataLatch;
							next_r.sdaOe = ~r.dataLatch[7];
							next_r.st = lhci_pkg::D_TX;
						end else begin
							next_r.sdaOe = 1'b0;
							next_r.st = lhci_pkg::D_CTRL;
						end
					end
				end
				lhci_pkg::D_TX: begin
					if (sclFall) begin
						if (r.bitCnt == 4'h7) begin
							next_r.sdaOe = 1'b0;
							next_r.st = lhci_pkg::D_MACK;
						end else begin
							next_r.shift = {r.shift[6:0], 1'b0};
							next_r.sdaOe = ~r.shift[6];
							next_r.bitCnt = r.bitCnt + 4'h1;
						end
					end
				end
				lhci_pkg::D_MACK: begin
					if (sclRise) begin
						if (~bus.sdaLine) begin
							next_r.dataLatch = r.ram[r.ac];
							next_r.shift = r.ram[r.ac];
							next_r.ac = stepAc(r.ac, r.inc);
							next_r.st = lhci_pkg::D_LOAD;
						end else begin
							// No ack: latch, counter and cursor untouched
							next_r.st = lhci_pkg::D_IDLE;
						end
					end
				end
				lhci_pkg::D_LOAD: begin
					if (sclFall) begin
						next_r.bitCnt = 4'h0;
						next_r.sdaOe = ~r.shift[7];
						next_r.st = lhci_pkg::D_TX;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.sclPrev <= 1'b1;
			r.sdaPrev <= 1'b1;
			r.inc <= 1'b1;
			r.wide <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign bus.sdaDevOut = 1'b0;
	assign bus.sdaDevOe = r.sdaOe;
	assign bus.busyFlag = r.busy;
	assign addressCounter = r.ac;
	assign dataLatch = r.dataLatch;
	assign displayOn = r.dispOn;
	assign wideBus = r.wide;
	assign funcBits = r.funcBits;
	assign entryInc = r.inc;
	assign entryShift = r.shiftEn;
endmodule
`default_nettype wire

/* File: design/lhci_host_end.sv */
/*
 Host end: reset-time instruction sequence over the parallel port,
 single data writes, and serial readback of display data RAM.
 Assumes the device end shares ref_clk and the bus interface.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Device shifts byte MSB first; ack loads next
// - Missing ack leaves everything unchanged
// - Host pulls data line low in read ack slots, releases it for the last byte
// - Wait 2 ms, 2 ms, over 40 us unpolled
// - First three function sets 0011xxxx, write
// - Later: poll busy or wait execution time
// - Then lines, display off, clear, entry mode
// - Control byte RS=1 R/W=1 selects RAM reading
module lhci_host_end #(
	parameter int LONG_WAIT_CYC = lhci_pkg::LONG_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	lhci_bus_if.host bus,
	input wire logic pollBusy,
	input wire logic [2:0] cfgLines,
	input wire logic [1:0] cfgEntry,
	input wire logic wrReq,
	input wire logic [7:0] wrData,
	input wire logic readReq,
	input wire logic [3:0] readLen,
	output logic initDone,
	output logic hostBusy,
	output logic [7:0] readData,
	output logic readValid
);
	typedef struct packed {
		lhci_pkg::lhci_hstate_t hst;
		logic [2:0] idx;
		logic [lhci_pkg::CNT_W-1:0] cnt;
		logic pollNow;
		logic rs;
		logic [7:0] db;
		logic en;
		logic done;
		lhci_pkg::lhci_sstate_t sst;
		logic [1:0] q;
		logic [2:0] tick;
		logic [3:0] bitIdx;
		logic [2:0] seq;
		logic [3:0] left;
		logic [7:0] shift;
		logic rx;
		logic scl;
		logic sdaOe;
		logic [7:0] rdData;
		logic rdValid;
		logic hBusy;
	} lhci_host_t;

	lhci_host_t r, next_r;
	logic quarterEnd, itemEnd;
	logic [2:0] nextItem;

	function automatic logic [7:0] initInstr(input logic [2:0] idx,
		input logic [2:0] lines, input logic [1:0] entry);
		case (idx)
			3'h0, 3'h1, 3'h2: initInstr = lhci_pkg::FS_8BIT;
			3'h3: initInstr = {lhci_pkg::FS_PREFIX, 1'b1, lines, 1'b0};
			3'h4: initInstr = lhci_pkg::DISP_OFF;
			3'h5: initInstr = lhci_pkg::CLEAR_CMD;
			3'h6: initInstr = {lhci_pkg::ENTRY_PREFIX, entry};
			default: initInstr = 8'h00;
		endcase
	endfunction

	// Data line enable for one bit slot of a byte
	function automatic logic bitOe(input logic rx, input logic [3:0] b,
		input logic msb, input logic [3:0] left);
		if (b == 4'h8) begin
			bitOe = rx && (left > 4'h1);
		end else begin
			bitOe = ~rx & ~msb;
		end
	endfunction

	assign quarterEnd = (r.tick == 3'(lhci_pkg::QTR_CYC - 1));

	always_comb begin
		next_r = r;
		next_r.en = 1'b0;
		next_r.rdValid = 1'b0;
		itemEnd = 1'b0;
		nextItem = r.seq + 3'h1;
		case (r.hst)
			lhci_pkg::H_WAIT: begin
				if (r.cnt != '0) begin
					next_r.cnt = r.cnt - 1'b1;
				end else if (!(r.pollNow && bus.busyFlag)) begin
					if (r.idx == lhci_pkg::USER_IDX) begin
						next_r.hst = lhci_pkg::H_READY;
					end else begin
						next_r.hst = lhci_pkg::H_ISSUE;
					end
				end
			end
			lhci_pkg::H_ISSUE: begin
				// Register select 0, write, one-cycle enable
				next_r.rs = 1'b0;
				next_r.db = initInstr(r.idx, cfgLines, cfgEntry);
				next_r.en = 1'b1;
				next_r.hst = lhci_pkg::H_WAIT;
				next_r.pollNow = 1'b0;
				next_r.idx = r.idx + 3'h1;
				if (r.idx == 3'h0) begin
					next_r.cnt = lhci_pkg::CNT_W'(LONG_WAIT_CYC);
				end else if (r.idx == 3'h1) begin
					next_r.cnt = lhci_pkg::CNT_W'(lhci_pkg::SHORT_WAIT_CYC);
				end else if (pollBusy) begin
					next_r.cnt = lhci_pkg::CNT_W'(lhci_pkg::POLL_SETTLE_CYC);
					next_r.pollNow = 1'b1;
				end else begin
					next_r.cnt = lhci_pkg::CNT_W'(lhci_pkg::HOST_EXEC_CYC);
				end
				if (r.idx == lhci_pkg::LAST_INIT_IDX) begin
					next_r.done = 1'b1;
				end
			end
			lhci_pkg::H_READY: begin
				if (wrReq) begin
					next_r.rs = 1'b1;
					next_r.db = wrData;
					next_r.en = 1'b1;
					next_r.pollNow = pollBusy;
					next_r.cnt = pollBusy ?
						lhci_pkg::CNT_W'(lhci_pkg::POLL_SETTLE_CYC) :
						lhci_pkg::CNT_W'(lhci_pkg::HOST_EXEC_CYC);
					next_r.hst = lhci_pkg::H_WAIT;
				end else if (readReq && readLen != 4'h0) begin
					next_r.hst = lhci_pkg::H_SER;
					next_r.sst = lhci_pkg::S_START;
					next_r.seq = 3'h0;
					next_r.left = readLen;
					next_r.q = 2'h0;
					next_r.tick = 3'h0;
					next_r.sdaOe = 1'b0;
				end
			end
			lhci_pkg::H_SER: begin
				next_r.tick = quarterEnd ? 3'h0 : r.tick + 3'h1;
				if (quarterEnd) begin
					next_r.q = r.q + 2'h1;
					case (r.sst)
						lhci_pkg::S_START: begin
							case (r.q)
								2'h0: next_r.scl = 1'b1;
								2'h1: next_r.sdaOe = 1'b1;
								2'h2: next_r.scl = 1'b0;
								default: itemEnd = 1'b1;
							endcase
						end
						lhci_pkg::S_BYTE: begin
							case (r.q)
								2'h0: next_r.scl = 1'b1;
								2'h1: begin
									if (r.rx && r.bitIdx < 4'h8) begin
										next_r.shift = {r.shift[6:0], bus.sdaLine};
										if (r.bitIdx == 4'h7) begin
											next_r.rdData = {r.shift[6:0], bus.sdaLine};
											next_r.rdValid = 1'b1;
										end
									end
								end
								2'h2: next_r.scl = 1'b0;
								default: begin
									if (r.bitIdx == 4'h8) begin
										itemEnd = 1'b1;
										if (r.rx) begin
											next_r.left = r.left - 4'h1;
											nextItem = (r.left > 4'h1) ? 3'h5 : 3'h6;
										end
									end else begin
										next_r.bitIdx = r.bitIdx + 4'h1;
										if (!r.rx) begin
											next_r.shift = {r.shift[6:0], 1'b0};
										end
										next_r.sdaOe = bitOe(r.rx, r.bitIdx + 4'h1,
											r.shift[6], r.left);
									end
								end
							endcase
						end
						lhci_pkg::S_STOP: begin
							case (r.q)
								2'h0: next_r.scl = 1'b1;
								2'h1: next_r.sdaOe = 1'b0;
								2'h2: begin
								end
								default: next_r.hst = lhci_pkg::H_READY;
							endcase
						end
						default: next_r.hst = lhci_pkg::H_READY;
					endcase
				end
				if (itemEnd) begin
					next_r.seq = nextItem;
					next_r.bitIdx = 4'h0;
					next_r.q = 2'h0;
					next_r.rx = 1'b0;
					next_r.sst = lhci_pkg::S_BYTE;
					case (nextItem)
						3'h1: next_r.shift = {lhci_pkg::SLAVE_ADDR, 1'b0};
						3'h2: next_r.shift = lhci_pkg::CTRL_READ;
						3'h3: next_r.sst = lhci_pkg::S_START;
						3'h4: next_r.shift = {lhci_pkg::SLAVE_ADDR, 1'b1};
						3'h5: next_r.rx = 1'b1;
						default: next_r.sst = lhci_pkg::S_STOP;
					endcase
					if (nextItem == 3'h3) begin
						next_r.sdaOe = 1'b0;
					end else if (nextItem >= 3'h6) begin
						next_r.sdaOe = 1'b1;
					end else begin
						next_r.sdaOe = bitOe(next_r.rx, 4'h0, next_r.shift[7],
							r.left);
					end
				end
			end
			default: next_r.hst = lhci_pkg::H_WAIT;
		endcase
		// Registered so the output comes straight from a flop
		next_r.hBusy = (next_r.hst != lhci_pkg::H_READY);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.hst <= lhci_pkg::H_WAIT;
			// No busy polling before the first three commands
			r.cnt <= lhci_pkg::CNT_W'(LONG_WAIT_CYC);
			r.scl <= 1'b1;
			r.hBusy <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign bus.scl = r.scl;
	assign bus.sdaHostOut = 1'b0;
	assign bus.sdaHostOe = r.sdaOe;
	assign bus.registerSelect = r.rs;
	assign bus.readWrite = 1'b0;
	assign bus.dataBus = r.db;
	assign bus.enable = r.en;
	assign initDone = r.done;
	assign hostBusy = r.hBusy;
	assign readData = r.rdData;
	assign readValid = r.rdValid;
endmodule
`default_nettype wire

/* File: dv/lhci_checker.sv */
/*
 Checker on the host-device link: command order and spacing, busy flag,
 serial line discipline. Assumes one clock and a synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module lhci_checker #(
	parameter int LONG_WAIT_CYC = lhci_pkg::LONG_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sdaHostOe,
	input wire logic sdaDevOe,
	input wire logic sdaLine,
	input wire logic registerSelect,
	input wire logic readWrite,
	input wire logic [7:0] dataBus,
	input wire logic enable,
	input wire logic busyFlag
);
	logic [2:0] cmdCount;
	int gapCnt;
	int busyCnt;
	logic [7:0] lastCmd;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Saturates: only the first seven commands are ordered
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmdCount <= 3'h0;
			gapCnt <= 0;
			busyCnt <= 0;
			lastCmd <= 8'h00;
		end else begin
			// Previous command, so ordering needs no long delay range
			lastCmd <= enable ? dataBus : lastCmd;
			cmdCount <= (enable && cmdCount != 3'h7) ? cmdCount + 3'h1 : cmdCount;
			gapCnt <= enable ? 0 : gapCnt + 1;
			busyCnt <= enable ? 0 : (busyFlag ? busyCnt + 1 : busyCnt);
		end
	end
	init_fs_a: assert property (
		enable && cmdCount < 3'h3 |->
		!registerSelect && !readWrite && dataBus[7:4] == 4'h3)
		else $error("early function set malformed");
	gap_long_a: assert property (
		enable && cmdCount < 3'h2 |-> gapCnt >= LONG_WAIT_CYC - 1)
		else $error("long wait cut short");
	gap_short_a: assert property (
		enable && cmdCount == 3'h2 |-> gapCnt >= lhci_pkg::SHORT_WAIT_CYC - 1)
		else $error("short wait cut short");
	no_cmd_busy_a: assert property (
		enable && cmdCount >= 3'h3 |-> !busyFlag)
		else $error("command issued while busy");
	busy_rise_a: assert property (
		enable |=> busyFlag)
		else $error("busy flag did not rise");
	busy_len_a: assert property (
		busyFlag |-> busyCnt <= lhci_pkg::EXEC_CYC)
		else $error("busy flag held too long");
	func_lines_a: assert property (
		enable && cmdCount == 3'h3 |->
		!registerSelect && dataBus[7:4] == 4'h3 && !dataBus[0])
		else $error("fourth function set malformed");
	tail_cmds_a: assert property (
		enable && cmdCount == 3'h5 |-> dataBus == lhci_pkg::CLEAR_CMD &&
		lastCmd == lhci_pkg::DISP_OFF && gapCnt >= lhci_pkg::EXEC_CYC - 1)
		else $error("display off or clear out of order");
	entry_cmd_a: assert property (
		enable && cmdCount == 3'h6 |-> dataBus[7:2] == lhci_pkg::ENTRY_PREFIX)
		else $error("entry mode command malformed");
	shift_stable_a: assert property (
		scl && $past(scl) |-> $stable(sdaDevOe))
		else $error("device data moved while clock high");
	stop_idle_a: assert property (
		scl && $past(scl) && $rose(sdaLine) |=> !sdaDevOe [*4])
		else $error("device drove line after stop");
	host_release_a: assert property (
		sdaDevOe && scl |-> !sdaHostOe)
		else $error("host drove line during device slot");
	init_end_c: cover property (enable && cmdCount == 3'h6);
	stop_c: cover property (scl && $past(scl) && $rose(sdaLine));
	dev_drive_c: cover property (sdaDevOe && scl);
endmodule
`default_nettype wire

/* File: dv/test_lcd_host_command_interface.sv */
/*
 Bench joining host and device ends over the link interface.
 Assumes design files, interface and checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		failures++; \
		$display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module test_lcd_host_command_interface;
	// Short long-wait keeps the run small
	localparam int LW = 50;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic pollBusy = 1'b0;
	logic [2:0] cfgLines = 3'h5;
	logic [1:0] cfgEntry = 2'h2;
	logic wrReq = 1'b0;
	logic [7:0] wrData = 8'h00;
	logic readReq = 1'b0;
	logic [3:0] readLen = 4'h1;
	logic initDone;
	logic hostBusy;
	logic readValid;
	logic [7:0] readData;
	logic [7:0] dataLatch;
	logic [6:0] addressCounter;
	logic displayOn;
	logic wideBus;
	logic entryInc;
	logic entryShift;
	logic [2:0] funcBits;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	int bitN = 0;
	int mac = 0;
	logic [8:0] sh = 9'h000;
	logic prevScl = 1'b1;
	logic prevSda = 1'b1;
	logic [8:0] cmdQ[$];
	int stampQ[$];
	logic [7:0] byteQ[$];
	logic ackQ[$];
	logic [7:0] ram[80];

	always #5 ref_clk = ~ref_clk;

	lhci_bus_if lhci_bus_if_i();
	lhci_host_end #(.LONG_WAIT_CYC(LW)) lhci_host_end_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .bus(lhci_bus_if_i), .pollBusy(pollBusy),
		.cfgLines(cfgLines), .cfgEntry(cfgEntry), .wrReq(wrReq),
		.wrData(wrData), .readReq(readReq), .readLen(readLen),
		.initDone(initDone), .hostBusy(hostBusy), .readData(readData),
		.readValid(readValid));
	lhci_device_end lhci_device_end_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.bus(lhci_bus_if_i), .addressCounter(addressCounter),
		.dataLatch(dataLatch), .displayOn(displayOn), .wideBus(wideBus),
		.funcBits(funcBits), .entryInc(entryInc), .entryShift(entryShift));
	lhci_checker #(.LONG_WAIT_CYC(LW)) lhci_checker_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .scl(lhci_bus_if_i.scl),
		.sdaHostOe(lhci_bus_if_i.sdaHostOe), .sdaDevOe(lhci_bus_if_i.sdaDevOe),
		.sdaLine(lhci_bus_if_i.sdaLine),
		.registerSelect(lhci_bus_if_i.registerSelect),
		.readWrite(lhci_bus_if_i.readWrite), .dataBus(lhci_bus_if_i.dataBus),
		.enable(lhci_bus_if_i.enable), .busyFlag(lhci_bus_if_i.busyFlag));

	// Wire monitor: commands with stamps, serial bytes with ack bits
	always @(posedge ref_clk) begin
		cyc = rst_n ? cyc + 1 : 0;
		prevScl <= lhci_bus_if_i.scl;
		prevSda <= lhci_bus_if_i.sdaLine;
		if (rst_n && lhci_bus_if_i.enable) begin
			cmdQ.push_back({lhci_bus_if_i.registerSelect, lhci_bus_if_i.dataBus});
			stampQ.push_back(cyc);
		end
		if (lhci_bus_if_i.scl && prevScl && prevSda && !lhci_bus_if_i.sdaLine)
			bitN = 0;
		else if (lhci_bus_if_i.scl && !prevScl) begin
			sh = {sh[7:0], lhci_bus_if_i.sdaLine};
			bitN++;
			if (bitN == 9) begin
				byteQ.push_back(sh[8:1]);
				ackQ.push_back(sh[0]);
				bitN = 0;
			end
		end
	end

	task automatic tally_and_finish();
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk);
		while (hostBusy !== 1'b0 && n < 30000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("hostBusy", 1'b0, hostBusy)
	endtask

	task automatic do_init(input logic poll, input logic [2:0] lines,
		input logic [1:0] entry);
		logic [8:0] exp;
		int gapLen;
		int gapMin;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		pollBusy <= poll;
		cfgLines <= lines;
		cfgEntry <= entry;
		repeat (5) @(posedge ref_clk);
		cmdQ.delete();
		stampQ.delete();
		rst_n <= 1'b1;
		wait_ready();
		`CHK("initDone", 1'b1, initDone)
		`CHK("command count", 7, cmdQ.size())
		for (int i = 0; i < 7 && i < cmdQ.size(); i++) begin
			case (i)
				0, 1, 2: exp = {1'b0, lhci_pkg::FS_8BIT};
				3: exp = {5'h03, lines, 1'b0};
				4: exp = {1'b0, lhci_pkg::DISP_OFF};
				5: exp = {1'b0, lhci_pkg::CLEAR_CMD};
				default: exp = {1'b0, lhci_pkg::ENTRY_PREFIX, entry};
			endcase
			`CHK("command", exp, cmdQ[i])
			gapLen = (i == 0) ? stampQ[0] : stampQ[i] - stampQ[i - 1];
			gapMin = (i < 2) ? LW : lhci_pkg::EXEC_CYC + ((i == 2) ? 1 : 0);
			`CHK("command gap", 1'b1, gapLen >= gapMin)
		end
		`CHK("wideBus", 1'b1, wideBus)
		`CHK("funcBits", lines, funcBits)
		`CHK("displayOn", 1'b0, displayOn)
		`CHK("entry", entry, {entryInc, entryShift})
		`CHK("ac cleared", 7'h00, addressCounter)
	endtask

	task automatic write_byte(input logic [7:0] d);
		@(posedge ref_clk);
		wrReq <= 1'b1;
		wrData <= d;
		@(posedge ref_clk);
		wrReq <= 1'b0;
		ram[mac] = d;
		mac = (mac + 1) % 80;
		wait_ready();
	endtask

	task automatic read_bytes(input int n);
		int a0;
		int k;
		a0 = mac;
		byteQ.delete();
		ackQ.delete();
		@(posedge ref_clk);
		readReq <= 1'b1;
		readLen <= n[3:0];
		@(posedge ref_clk);
		readReq <= 1'b0;
		for (int i = 0; i < n; i++) begin
			k = 0;
			@(negedge ref_clk);
			while (readValid !== 1'b1 && k < 2000) begin
				@(negedge ref_clk);
				k++;
			end
			`CHK("readData", ram[(a0 + i) % 80], readData)
		end
		wait_ready();
		mac = (a0 + n) % 80;
		`CHK("frame bytes", n + 3, byteQ.size())
		`CHK("write address", {lhci_pkg::SLAVE_ADDR, 1'b0}, byteQ[0])
		`CHK("control byte", lhci_pkg::CTRL_READ, byteQ[1])
		`CHK("read address", {lhci_pkg::SLAVE_ADDR, 1'b1}, byteQ[2])
		for (int i = 0; i < n; i++) begin
			`CHK("wire byte", ram[(a0 + i) % 80], byteQ[3 + i])
			`CHK("ack bit", i == n - 1, ackQ[3 + i])
		end
		`CHK("ac after read", mac[6:0], addressCounter)
		`CHK("latch", ram[(a0 + n - 1) % 80], dataLatch)
	endtask

	initial begin
		for (int i = 0; i < 80; i++) ram[i] = lhci_pkg::BLANK_CHAR;
		do_init(1'b0, 3'h5, 2'h2);
		write_byte(8'h48);
		write_byte(8'h49);
		`CHK("ac after writes", 7'h02, addressCounter)
		// Five long reads and the first short read walk the counter round to the written bytes
		repeat (5) read_bytes(15);
		read_bytes(3);
		read_bytes(3);
		do_init(1'b1, 3'h2, 2'h3);
		tally_and_finish();
	end

	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
